// >>> design/asbq_rx.sv
`default_nettype none

module asbq_rx (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic receiver_bit_clock,
  input wire logic rxd,
  input wire logic mode_64x,
  input wire logic [1:0] char_len,
  input wire logic parity_enable,
  input wire logic parity_even,
  input wire logic host_read,
  input wire logic error_clear,
  output logic [7:0] rx_data,
  output logic rx_data_avail,
  output logic parity_error,
  output logic framing_error,
  output logic overrun_error,
  output logic break_detect
);

  // ----------------------------------------
  // receive-side state (receiver_bit_clock domain)
  // ----------------------------------------
  typedef struct packed {
    asbq_pkg::asbq_rx_state_e state;
    logic [5:0] cnt;
    logic [2:0] bit_idx;
    logic [asbq_pkg::DATA_W-1:0] shreg;
    logic par_acc;
    logic perr;
    logic any_high;
    logic tog;
    logic [asbq_pkg::DATA_W-1:0] res_data;
    logic res_perr;
    logic res_ferr;
    logic res_brk;
  } asbq_rxd_s;

  // ----------------------------------------
  // host-side state (clk domain)
  // ----------------------------------------
  typedef struct packed {
    logic tog_seen;
    logic [asbq_pkg::DATA_W-1:0] data;
    logic avail;
    logic perr;
    logic ferr;
    logic ovr;
    logic brk;
  } asbq_hst_s;

  asbq_rxd_s rx_r;
  asbq_rxd_s rx_nxt;
  asbq_hst_s hs_r;
  asbq_hst_s hs_nxt;

  logic rxd_s;
  logic [asbq_pkg::CFG_W-1:0] cfg_s;
  logic tog_s;
  logic cfg_64x;
  logic cfg_pen;
  logic cfg_peven;
  logic [1:0] cfg_len;
  logic [5:0] os_last;
  logic [5:0] start_last;
  logic [2:0] last_bit;
  logic new_char;

  // ----------------------------------------
  // crossings into the link domain
  // ----------------------------------------
  asbq_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_rxd_sync (
    .clk(receiver_bit_clock),
    .rst_n(rst_n),
    .d(rxd),
    .q(rxd_s)
  );

  // format inputs are expected to be static while a character is in flight
  asbq_sync #(.WIDTH(asbq_pkg::CFG_W), .RESET_VAL(5'h00)) u_cfg_sync (
    .clk(receiver_bit_clock),
    .rst_n(rst_n),
    .d({char_len, parity_even, parity_enable, mode_64x}),
    .q(cfg_s)
  );

  assign cfg_64x = cfg_s[0];
  assign cfg_pen = cfg_s[1];
  assign cfg_peven = cfg_s[2];
  assign cfg_len = cfg_s[4:3];
  assign os_last = cfg_64x ? asbq_pkg::OS64_LAST : asbq_pkg::OS16_LAST;
  assign start_last = cfg_64x ? asbq_pkg::START_LAST_64 : asbq_pkg::START_LAST_16;
  assign last_bit = asbq_pkg::LAST_BIT_BASE + {1'b0, cfg_len};

  // ----------------------------------------
  // receiver state machine
  // ----------------------------------------
  always_comb begin
    rx_nxt = rx_r;
    case (rx_r.state)
      asbq_pkg::ASBQ_IDLE: begin
        if (!rxd_s) begin
          rx_nxt.state = asbq_pkg::ASBQ_START;
          rx_nxt.cnt = asbq_pkg::CNT_ONE;
        end
      end
      asbq_pkg::ASBQ_START: begin
        if (rxd_s) begin
          // glitch: back to hunting, nothing reaches the host
          rx_nxt.state = asbq_pkg::ASBQ_IDLE;
        end else if (rx_r.cnt == start_last) begin
          // accepting exactly at half a bit gives a clean cut: a pulse of
          // half a bit is a real start, sampled at the last oversample of each bit
          rx_nxt.state = asbq_pkg::ASBQ_DATA;
          rx_nxt.cnt = asbq_pkg::CNT_ZERO;
          rx_nxt.bit_idx = '0;
          rx_nxt.shreg = '0;
          rx_nxt.par_acc = 1'b0;
          rx_nxt.any_high = 1'b0;
          rx_nxt.perr = 1'b0;
        end else begin
          rx_nxt.cnt = rx_r.cnt + asbq_pkg::CNT_ONE;
        end
      end
      asbq_pkg::ASBQ_DATA: begin
        if (rx_r.cnt == os_last) begin
          rx_nxt.cnt = asbq_pkg::CNT_ZERO;
          rx_nxt.shreg = {rxd_s, rx_r.shreg[asbq_pkg::DATA_W-1:1]};
          rx_nxt.par_acc = rx_r.par_acc ^ rxd_s;
          rx_nxt.any_high = rx_r.any_high | rxd_s;
          if (rx_r.bit_idx == last_bit) begin
            rx_nxt.state = cfg_pen ? asbq_pkg::ASBQ_PARITY : asbq_pkg::ASBQ_STOP;
          end else begin
            rx_nxt.bit_idx = rx_r.bit_idx + 3'h1;
          end
        end else begin
          rx_nxt.cnt = rx_r.cnt + asbq_pkg::CNT_ONE;
        end
      end
      asbq_pkg::ASBQ_PARITY: begin
        if (rx_r.cnt == os_last) begin
          rx_nxt.cnt = asbq_pkg::CNT_ZERO;
          rx_nxt.any_high = rx_r.any_high | rxd_s;
          // even: data plus parity bit has no odd count of ones
          rx_nxt.perr = rx_r.par_acc ^ rxd_s ^ ~cfg_peven;
          rx_nxt.state = asbq_pkg::ASBQ_STOP;
        end else begin
          rx_nxt.cnt = rx_r.cnt + asbq_pkg::CNT_ONE;
        end
      end
      asbq_pkg::ASBQ_STOP: begin
        if (rx_r.cnt == os_last) begin
          rx_nxt.cnt = asbq_pkg::CNT_ZERO;
          // result is only published with a complete character, so a
          // break that ends mid-frame cannot leave a stray parity flag
          rx_nxt.res_data = rx_r.shreg >> (asbq_pkg::ALIGN_MAX - cfg_len);
          rx_nxt.res_perr = rx_r.perr;
          rx_nxt.res_ferr = ~rxd_s;
          rx_nxt.res_brk = ~rxd_s & ~rx_r.any_high;
          rx_nxt.tog = ~rx_r.tog;
          // a low stop bit means the line may be held in break: wait for
          // it to return high so its end is not taken as a new start
          rx_nxt.state = rxd_s ? asbq_pkg::ASBQ_IDLE : asbq_pkg::ASBQ_BRKWAIT;
        end else begin
          rx_nxt.cnt = rx_r.cnt + asbq_pkg::CNT_ONE;
        end
      end
      asbq_pkg::ASBQ_BRKWAIT: begin
        if (rxd_s) begin
          rx_nxt.state = asbq_pkg::ASBQ_IDLE;
        end
      end
      default: begin
        rx_nxt.state = asbq_pkg::ASBQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge receiver_bit_clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_r <= '0;
    end else begin
      rx_r <= rx_nxt;
    end
  end

  // ----------------------------------------
  // character hand-over to the host domain
  // ----------------------------------------
  // res_* stand still for a whole character time after the toggle,
  // far longer than the three clk edges the toggle needs to cross
  asbq_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_tog_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(rx_r.tog),
    .q(tog_s)
  );

  assign new_char = tog_s ^ hs_r.tog_seen;

  always_comb begin
    hs_nxt = hs_r;
    hs_nxt.tog_seen = tog_s;
    if (host_read) begin
      hs_nxt.avail = 1'b0;
    end
    if (error_clear) begin
      hs_nxt.ovr = 1'b0;
    end
    if (new_char) begin
      hs_nxt.data = rx_r.res_data;
      hs_nxt.perr = rx_r.res_perr;
      hs_nxt.ferr = rx_r.res_ferr;
      hs_nxt.brk = rx_r.res_brk;
      hs_nxt.avail = 1'b1;
      if (hs_r.avail && !host_read) begin
        hs_nxt.ovr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_r <= '0;
    end else begin
      hs_r <= hs_nxt;
    end
  end

  assign rx_data = hs_r.data;
  assign rx_data_avail = hs_r.avail;
  assign parity_error = hs_r.perr;
  assign framing_error = hs_r.ferr;
  assign overrun_error = hs_r.ovr;
  assign break_detect = hs_r.brk;

endmodule // asbq_rx

`default_nettype wire

// >>> pkg/asbq_pkg.sv
`default_nettype none

package asbq_pkg;

  // ----------------------------------------
  // oversampling counts (receiver clock periods)
  // ----------------------------------------
  localparam logic [5:0] OS16_LAST = 6'h0F;
  localparam logic [5:0] OS64_LAST = 6'h3F;
  // start accepted on the low sample that reaches half a bit
  localparam logic [5:0] START_LAST_16 = 6'h07;
  localparam logic [5:0] START_LAST_64 = 6'h1F;
  localparam logic [5:0] CNT_ONE = 6'h01;
  localparam logic [5:0] CNT_ZERO = 6'h00;

  // ----------------------------------------
  // character format
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int CFG_W = 5;
  localparam logic [2:0] LAST_BIT_BASE = 3'h4;
  localparam logic [1:0] ALIGN_MAX = 2'h3;

  // ----------------------------------------
  // receiver states, gray from IDLE through STOP along the parity path
  // ----------------------------------------
  typedef enum logic [2:0] {
    ASBQ_IDLE = 3'h0,
    ASBQ_START = 3'h1,
    ASBQ_DATA = 3'h3,
    ASBQ_PARITY = 3'h2,
    ASBQ_STOP = 3'h6,
    ASBQ_BRKWAIT = 3'h7
  } asbq_rx_state_e;

endpackage : asbq_pkg

`default_nettype wire

// >>> design/asbq_sync.sv
`default_nettype none

// two-flop synchroniser; meta is read by the second stage only
module asbq_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } asbq_sync_s;

  asbq_sync_s st_r;
  asbq_sync_s st_nxt;

  always_comb begin
    st_nxt.meta = d;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{meta: RESET_VAL, sync: RESET_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.sync;

endmodule // asbq_sync

`default_nettype wire

// >>> verification/asbq_rx_monitor.sv
`default_nettype none
// ----------------------------------------
// receive checks, host clock domain
// ----------------------------------------
module asbq_rx_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic receiver_bit_clock,
  input wire logic rxd,
  input wire logic mode_64x,
  input wire logic [1:0] char_len,
  input wire logic parity_enable,
  input wire logic parity_even,
  input wire logic host_read,
  input wire logic error_clear,
  input wire logic [7:0] rx_data,
  input wire logic rx_data_avail,
  input wire logic parity_error,
  input wire logic framing_error,
  input wire logic overrun_error,
  input wire logic break_detect
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_AVAIL_HOLDS: assert property (rx_data_avail && !host_read |=> rx_data_avail)
    else $error("avail dropped early");
  AST_READ_CLEARS: assert property ($fell(rx_data_avail) |-> $past(host_read))
    else $error("avail fell without read");
  AST_PAR_AT_CHAR: assert property ($changed(parity_error) |-> rx_data_avail)
    else $error("parity flag moved with no char");
  AST_DATA_AT_CHAR: assert property ($changed(rx_data) |-> rx_data_avail)
    else $error("data moved with no char");
  AST_BRK_ZERO: assert property (break_detect |-> rx_data == 8'h00 && framing_error)
    else $error("break with data or no framing");
  AST_OVR_CAUSE: assert property ($rose(overrun_error) |-> $past(rx_data_avail) && rx_data_avail)
    else $error("overrun with nothing pending");
  AST_OVR_STICKY: assert property (overrun_error && !error_clear |=> overrun_error)
    else $error("overrun lost");
  AST_RESET_CLEAN: assert property ($rose(rst_n) |-> !rx_data_avail && !break_detect)
    else $error("output set out of reset");
  cover property ($rose(rx_data_avail));
  cover property ($rose(break_detect));
  cover property ($rose(parity_error));
  cover property ($rose(overrun_error));
endmodule // asbq_rx_monitor
`default_nettype wire

// >>> verification/asbq_tx_model.sv
`default_nettype none
// ----------------------------------------
// remote transmitter, idle high line
// ----------------------------------------
module asbq_tx_model (
  input wire logic receiver_bit_clock,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxd = 1'b1;
  task automatic bits(input logic v, input int n);
    @(posedge receiver_bit_clock);
    rxd <= v;
    repeat (n - 1) @(posedge receiver_bit_clock);
  endtask
  // returns as the stop bit starts so the caller can look before it ends
  task automatic frame_n(input int st, input logic [7:0] d, input int nb, input logic pen, input logic p,
    input int os);
    bits(1'b0, st);
    for (int i = 0; i < nb; i++) bits(d[i], os);
    if (pen) bits(p, os);
    bits(1'b1, 1);
  endtask
  task automatic frame(input int st, input logic [7:0] d, input logic p, input int os);
    frame_n(st, d, 8, 1'b1, p, os);
  endtask
endmodule // asbq_tx_model
`default_nettype wire

// >>> verification/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic receiver_bit_clock = 1'b0;
  logic rst_n;
  logic mode_64x = 1'b0;
  logic host_read = 1'b0;
  logic [1:0] char_len = 2'h3;
  logic parity_enable = 1'b1;
  logic parity_even = 1'b1;
  logic error_clear = 1'b0;
  logic rxd;
  logic [7:0] rx_data;
  logic rx_data_avail, parity_error, framing_error, overrun_error, break_detect;
  int miscompares = 0;
  int tests_run = 0;
  always #10 clk = ~clk;
  initial begin
    #7;
    forever #80 receiver_bit_clock = ~receiver_bit_clock;
  end
  asbq_tx_model u_asbq_tx_model (.receiver_bit_clock, .rxd);
  asbq_rx u_asbq_rx (.clk, .rst_n, .receiver_bit_clock, .rxd, .mode_64x, .char_len,
    .parity_enable, .parity_even, .host_read, .error_clear, .rx_data,
    .rx_data_avail, .parity_error, .framing_error, .overrun_error, .break_detect);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // waits bounded, judges the char, then reads it away
  task automatic get(input logic [7:0] d, input logic pe, input logic brk);
    int n;
    n = 0;
    @(negedge clk);
    while (rx_data_avail !== 1'b1 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    chk("avail", 8'h01, {7'h00, rx_data_avail});
    chk("data", d, rx_data);
    chk("parity", {7'h00, pe}, {7'h00, parity_error});
    chk("break", {7'h00, brk}, {7'h00, break_detect});
    // only a break leaves the stop bit low in these scenarios
    chk("framing", {7'h00, brk}, {7'h00, framing_error});
    @(posedge clk) host_read <= 1'b1;
    @(posedge clk) host_read <= 1'b0;
    @(negedge clk);
    chk("avail", 8'h00, {7'h00, rx_data_avail});
  endtask
  task automatic t_glitch;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk) mode_64x <= m[0];
      u_asbq_tx_model.bits(1'b1, 8);
      u_asbq_tx_model.bits(1'b0, m ? 30 : 6);
      // long enough for a wrongly accepted glitch to complete a character
      u_asbq_tx_model.bits(1'b1, m ? 720 : 180);
      @(negedge clk);
      chk("avail", 8'h00, {7'h00, rx_data_avail});
      u_asbq_tx_model.frame(m ? 64 : 16, 8'hA5, 1'b0, m ? 64 : 16);
      get(8'hA5, 1'b0, 1'b0);
    end
    $display("glitch test done");
  endtask
  task automatic t_start;
    int st [6] = '{9, 8, 16, 33, 32, 64};
    logic [7:0] d;
    for (int i = 0; i < 6; i++) begin
      d = 8'h5A ^ i[7:0];
      @(posedge clk) mode_64x <= (i > 2);
      u_asbq_tx_model.bits(1'b1, 8);
      u_asbq_tx_model.frame(st[i], d, 1'b1, i > 2 ? 64 : 16);
      @(negedge clk);
      chk("early", 8'h00, {7'h00, rx_data_avail});
      get(d, ~^d, 1'b0);
    end
    $display("start length test done");
  endtask
  // the line rises again inside the parity slot of the second frame time
  task automatic t_break;
    @(posedge clk) mode_64x <= 1'b0;
    u_asbq_tx_model.bits(1'b1, 8);
    u_asbq_tx_model.bits(1'b0, 328);
    u_asbq_tx_model.bits(1'b1, 32);
    get(8'h00, 1'b0, 1'b1);
    u_asbq_tx_model.frame(16, 8'h81, 1'b0, 16);
    get(8'h81, 1'b0, 1'b0);
    $display("break test done");
  endtask
  task automatic t_overrun;
    @(posedge clk) mode_64x <= 1'b0;
    u_asbq_tx_model.bits(1'b1, 8);
    u_asbq_tx_model.frame(16, 8'h3C, 1'b0, 16);
    u_asbq_tx_model.bits(1'b1, 24);
    u_asbq_tx_model.frame(16, 8'hC3, 1'b0, 16);
    u_asbq_tx_model.bits(1'b1, 32);
    @(negedge clk);
    chk("overrun", 8'h01, {7'h00, overrun_error});
    get(8'hC3, 1'b0, 1'b0);
    @(posedge clk) error_clear <= 1'b1;
    @(posedge clk) error_clear <= 1'b0;
    @(negedge clk);
    chk("overrun", 8'h00, {7'h00, overrun_error});
    $display("overrun test done");
  endtask
  // five bits with odd parity, then seven bits without parity
  task automatic t_format;
    @(posedge clk) begin
      char_len <= 2'h0;
      parity_even <= 1'b0;
    end
    u_asbq_tx_model.bits(1'b1, 8);
    u_asbq_tx_model.frame_n(16, 8'h13, 5, 1'b1, 1'b0, 16);
    get(8'h13, 1'b0, 1'b0);
    @(posedge clk) begin
      char_len <= 2'h2;
      parity_enable <= 1'b0;
    end
    u_asbq_tx_model.bits(1'b1, 8);
    u_asbq_tx_model.frame_n(16, 8'h55, 7, 1'b0, 1'b0, 16);
    get(8'h55, 1'b0, 1'b0);
    $display("format test done");
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #1500000;
    miscompares++;
    stop_test();
  end
  initial begin
    // the falling edge at time zero resets the link domain before its first edge
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_glitch();
    t_start();
    t_break();
    t_overrun();
    t_format();
    stop_test();
  end
endmodule // tb_top
bind asbq_rx asbq_rx_monitor u_asbq_rx_monitor (.clk, .rst_n, .receiver_bit_clock, .rxd, .mode_64x,
  .char_len, .parity_enable, .parity_even, .host_read, .error_clear, .rx_data, .rx_data_avail,
  .parity_error, .framing_error, .overrun_error, .break_detect);
`default_nettype wire
